//--- design/pccr_defines.svh
// register offsets, field positions and timing figures of the common config
`ifndef PCCR_DEFINES_SVH
`define PCCR_DEFINES_SVH

`define PCCR_OFF_OFSEL   8'h00
`define PCCR_OFF_OFFER   8'h04
`define PCCR_OFF_ACCSEL  8'h08
`define PCCR_OFF_ACCEPT  8'h0C
`define PCCR_OFF_MISC    8'h10
`define PCCR_OFF_STATUS  8'h14
`define PCCR_OFF_QSIZE   8'h18
`define PCCR_OFF_QEN     8'h1C
`define PCCR_OFF_DESC_LO 8'h20
`define PCCR_OFF_DESC_HI 8'h24
`define PCCR_OFF_DRV_LO  8'h28
`define PCCR_OFF_DRV_HI  8'h2C
`define PCCR_OFF_DEV_LO  8'h30
`define PCCR_OFF_DEV_HI  8'h34
`define PCCR_OFF_QTAG    8'h38
`define PCCR_OFF_STRIDE  8'h3C

`define PCCR_LO16 15:0
`define PCCR_HI16 31:16
`define PCCR_B0   7:0
`define PCCR_LO32 31:0
`define PCCR_HI32 63:32
`define PCCR_QRST_BIT 16

`define PCCR_CAP_BASE_LEN   8'h10
`define PCCR_NOTIFY_XTRA    8'h04
`define PCCR_SLICE_LO       32'h0000_0000
`define PCCR_SLICE_HI       32'h0000_0001

`define PCCR_CLK_NS         100
`define PCCR_DEV_RESET_NS   2000
`define PCCR_QUEUE_RESET_NS 500

`endif

//--- design/pccr_pkg.sv
// types shared by the common configuration register block
package pccr_pkg;

  typedef enum logic [0:0]
  {
    PCCR_RUN       = 1'b0,
    PCCR_RESETTING = 1'b1
  } pccr_dev_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pccr_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } pccr_rsp_t;

endpackage : pccr_pkg

//--- design/pccr_common_cfg.sv
// common configuration register bank with per-queue banked fields
`include "pccr_defines.svh"

module pccr_common_cfg #(
  parameter int          NQ          = 4,
  parameter logic [15:0] QMAX        = 16'h0100,
  parameter logic [63:0] OFFERED     = 64'h0000_0184_0000_0000,
  parameter int          PACKED_BIT  = 34,
  parameter int          TAG_BIT     = 39,
  parameter int          RRESET_BIT  = 40,
  parameter logic [31:0] STRIDE      = 32'h0000_0004,
  parameter logic [31:0] NOTIFY_OFF  = 32'h0000_1000,
  parameter logic [31:0] COMMON_OFF  = 32'h0000_0000,
  parameter int DEV_RESET_CYCLES =
    (`PCCR_DEV_RESET_NS + `PCCR_CLK_NS - 1) / `PCCR_CLK_NS,
  parameter int QUEUE_RESET_CYCLES =
    (`PCCR_QUEUE_RESET_NS + `PCCR_CLK_NS - 1) / `PCCR_CLK_NS
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                clk_en,
  input  wire pccr_pkg::pccr_req_t acc,
  input  wire logic                dev_cfg_changed,
  input  wire logic                dev_cfg_read,
  output pccr_pkg::pccr_rsp_t      rsp,
  output logic [NQ-1:0]            ring_run,
  output logic [7:0]               function_state,
  output logic [7:0]               config_change_counter,
  output logic                     dev_resetting,
  output logic [31:0]              notify_addr,
  output logic [31:0]              common_region_off,
  output logic [7:0]               common_cap_len,
  output logic [7:0]               notify_cap_len
);

  localparam int QW = (NQ > 1) ? $clog2(NQ) : 1;

  typedef struct packed {
    pccr_pkg::pccr_dev_t     dstate;
    logic [15:0]             dcnt;
    logic [31:0]             ofsel;
    logic [31:0]             accsel;
    logic [63:0]             accepted;
    logic [15:0]             cfgvec;
    logic [15:0]             qsel;
    logic [7:0]              status;
    logic [7:0]              gen;
    logic                    changed;
    logic [NQ-1:0][15:0]     qsize;
    logic [NQ-1:0][15:0]     qvec;
    logic [NQ-1:0]           qen;
    logic [NQ-1:0]           qrst;
    logic [NQ-1:0][63:0]     qdesc;
    logic [NQ-1:0][63:0]     qdrv;
    logic [NQ-1:0][63:0]     qdev;
    logic                    qbusy;
    logic [QW-1:0]           qidx;
    logic [15:0]             qcnt;
    logic [NQ-1:0]           run;
    logic [31:0]             naddr;
    logic [31:0]             coff;
    logic [7:0]              clen;
    logic [7:0]              nlen;
    pccr_pkg::pccr_rsp_t     rsp;
  } pccr_state_t;

  pccr_state_t st;
  pccr_state_t next_st;

  function automatic pccr_state_t init_state();
    pccr_state_t s;
    s       = '0;
    s.qsize = {NQ{QMAX}};
    s.clen  = `PCCR_CAP_BASE_LEN;
    s.nlen  = `PCCR_CAP_BASE_LEN + `PCCR_NOTIFY_XTRA;
    s.coff  = {COMMON_OFF[31:2], 2'b00};
    return s;
  endfunction : init_state

  function automatic logic [31:0] merge32(input logic [31:0] old_w,
                                          input logic [31:0] new_w,
                                          input logic [3:0]  be);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[b*8 +: 8] = new_w[b*8 +: 8];
    return r;
  endfunction : merge32

  function automatic logic [31:0] slice64(input logic [63:0] v,
                                          input logic [31:0] sel);
    if (sel == `PCCR_SLICE_LO)
      return v[`PCCR_LO32];
    else if (sel == `PCCR_SLICE_HI)
      return v[`PCCR_HI32];
    else
      return '0;
  endfunction : slice64

  function automatic logic is_pow2(input logic [15:0] v);
    return (v != '0) && ((v & (v - 16'h0001)) == '0);
  endfunction : is_pow2

  function automatic logic [QW-1:0] first_set(input logic [NQ-1:0] v);
    logic [QW-1:0] r;
    r = '0;
    for (int i = NQ - 1; i >= 0; i--)
      if (v[i])
        r = QW'(i);
    return r;
  endfunction : first_set

  // notify index of a queue equals its number; so does its tag value once TAG_BIT is accepted, else the tag reads zero
  function automatic logic [15:0] notify_index(input logic [QW-1:0] q);
    return 16'(q);
  endfunction : notify_index

  always_comb
  begin
    logic [31:0]   cur;
    logic [31:0]   mw;
    logic [QW-1:0] idx;
    logic          qv;
    logic          packed_neg;
    logic          rr_neg;
    logic          tag_neg;
    logic          wr_ok;
    logic          bump;
    cur        = '0;
    mw         = '0;
    bump       = dev_cfg_read && st.changed;
    next_st    = st;
    idx        = st.qsel[QW-1:0];
    qv         = st.qsel < 16'(NQ);
    packed_neg = st.accepted[PACKED_BIT];
    rr_neg     = st.accepted[RRESET_BIT];
    tag_neg    = st.accepted[TAG_BIT];
    wr_ok      = acc.req && acc.wr && (st.dstate == pccr_pkg::PCCR_RUN);
    next_st.rsp.valid = 1'b0;

    unique case (acc.addr)
      `PCCR_OFF_OFSEL:   cur = st.ofsel;
      `PCCR_OFF_OFFER:   cur = slice64(OFFERED, st.ofsel);
      `PCCR_OFF_ACCSEL:  cur = st.accsel;
      `PCCR_OFF_ACCEPT:  cur = slice64(st.accepted, st.accsel);
      `PCCR_OFF_MISC:    cur = {16'(NQ), st.cfgvec};
      `PCCR_OFF_STATUS:  cur = {st.qsel, st.gen, st.status};
      `PCCR_OFF_QSIZE:   cur = qv ? {st.qvec[idx], st.qsize[idx]} : '0;
      `PCCR_OFF_QEN:     cur = qv ? {notify_index(idx), 15'h0000,
                                     st.qen[idx]} : '0;
      `PCCR_OFF_DESC_LO: cur = qv ? st.qdesc[idx][`PCCR_LO32] : '0;
      `PCCR_OFF_DESC_HI: cur = qv ? st.qdesc[idx][`PCCR_HI32] : '0;
      `PCCR_OFF_DRV_LO:  cur = qv ? st.qdrv[idx][`PCCR_LO32] : '0;
      `PCCR_OFF_DRV_HI:  cur = qv ? st.qdrv[idx][`PCCR_HI32] : '0;
      `PCCR_OFF_DEV_LO:  cur = qv ? st.qdev[idx][`PCCR_LO32] : '0;
      `PCCR_OFF_DEV_HI:  cur = qv ? st.qdev[idx][`PCCR_HI32] : '0;
      `PCCR_OFF_QTAG:    cur = qv ? {15'h0000, rr_neg & st.qrst[idx],
                                     tag_neg ? notify_index(idx)
                                             : 16'h0000} : '0;
      `PCCR_OFF_STRIDE:  cur = STRIDE;
      default:           cur = '0;
    endcase
    mw = merge32(cur, acc.wdata, acc.be);

    if (acc.req && !acc.wr)
    begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.rdata = cur;
    end

    // a change in the same cycle as the read stays pending
    if (bump)
    begin
      next_st.gen     = st.gen + 8'h01;
      next_st.changed = dev_cfg_changed;
    end
    else if (dev_cfg_changed)
      next_st.changed = 1'b1;

    // queue reset engine, one queue at a time, lowest first
    if (st.qbusy)
    begin
      if (st.qcnt == '0)
      begin
        next_st.qrst[st.qidx]  = 1'b0;
        next_st.qen[st.qidx]   = 1'b0;
        next_st.qsize[st.qidx] = QMAX;
        next_st.qvec[st.qidx]  = '0;
        next_st.qdesc[st.qidx] = '0;
        next_st.qdrv[st.qidx]  = '0;
        next_st.qdev[st.qidx]  = '0;
        next_st.qbusy          = 1'b0;
      end
      else
        next_st.qcnt = st.qcnt - 16'h0001;
    end
    else if (|st.qrst)
    begin
      next_st.qbusy = 1'b1;
      next_st.qidx  = first_set(st.qrst);
      next_st.qcnt  = 16'(QUEUE_RESET_CYCLES - 1);
    end

    if (wr_ok)
    begin
      unique case (acc.addr)
        `PCCR_OFF_OFSEL:  next_st.ofsel  = mw;
        `PCCR_OFF_ACCSEL: next_st.accsel = mw;
        `PCCR_OFF_ACCEPT:
        begin
          if (st.accsel == `PCCR_SLICE_LO)
            next_st.accepted[`PCCR_LO32] = mw & OFFERED[`PCCR_LO32];
          else if (st.accsel == `PCCR_SLICE_HI)
            next_st.accepted[`PCCR_HI32] = mw & OFFERED[`PCCR_HI32];
        end
        `PCCR_OFF_MISC:   next_st.cfgvec = mw[`PCCR_LO16];
        `PCCR_OFF_STATUS:
        begin
          next_st.qsel = mw[`PCCR_HI16];
          if (acc.be[0] && mw[`PCCR_B0] == 8'h00)
          begin
            next_st.dstate = pccr_pkg::PCCR_RESETTING;
            next_st.dcnt   = 16'(DEV_RESET_CYCLES - 1);
          end
          else
            next_st.status = mw[`PCCR_B0];
        end
        `PCCR_OFF_QSIZE:
          if (qv)
          begin
            next_st.qvec[idx] = mw[`PCCR_HI16];
            if (packed_neg ? (mw[`PCCR_LO16] != '0)
                           : is_pow2(mw[`PCCR_LO16]))
              next_st.qsize[idx] = mw[`PCCR_LO16];
          end
        `PCCR_OFF_QEN:
          if (qv && acc.be[0] && mw[0])
          begin
            next_st.qen[idx]  = 1'b1;
            next_st.qrst[idx] = 1'b0;
            // also cancels a queue that the engine picks up this cycle
            if (next_st.qbusy && next_st.qidx == idx)
              next_st.qbusy = 1'b0;
          end
        `PCCR_OFF_DESC_LO:
          if (qv) next_st.qdesc[idx][`PCCR_LO32] = mw;
        `PCCR_OFF_DESC_HI:
          if (qv) next_st.qdesc[idx][`PCCR_HI32] = mw;
        `PCCR_OFF_DRV_LO:
          if (qv) next_st.qdrv[idx][`PCCR_LO32] = mw;
        `PCCR_OFF_DRV_HI:
          if (qv) next_st.qdrv[idx][`PCCR_HI32] = mw;
        `PCCR_OFF_DEV_LO:
          if (qv) next_st.qdev[idx][`PCCR_LO32] = mw;
        `PCCR_OFF_DEV_HI:
          if (qv) next_st.qdev[idx][`PCCR_HI32] = mw;
        `PCCR_OFF_QTAG:
          if (qv && rr_neg && mw[`PCCR_QRST_BIT])
            next_st.qrst[idx] = 1'b1;
        default: ;
      endcase
    end

    if (st.dstate == pccr_pkg::PCCR_RESETTING)
    begin
      if (st.dcnt == '0)
      begin
        next_st         = init_state();
        // a config read on the completion edge still bumps generation
        next_st.gen     = bump ? st.gen + 8'h01 : st.gen;
        next_st.changed = bump ? dev_cfg_changed
                               : (st.changed | dev_cfg_changed);
        next_st.rsp     = st.rsp;
        next_st.rsp.valid = acc.req && !acc.wr;
        if (acc.req && !acc.wr)
          next_st.rsp.rdata = cur;
      end
      else
        next_st.dcnt = st.dcnt - 16'h0001;
    end

    next_st.run   = (next_st.dstate == pccr_pkg::PCCR_RUN)
                    ? (next_st.qen & ~next_st.qrst) : '0;
    next_st.naddr = NOTIFY_OFF + 32'(notify_index(next_st.qsel[QW-1:0])
                    * STRIDE);
    next_st.coff  = {COMMON_OFF[31:2], 2'b00};
    next_st.clen  = `PCCR_CAP_BASE_LEN;
    next_st.nlen  = `PCCR_CAP_BASE_LEN + `PCCR_NOTIFY_XTRA;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      st <= init_state();
    else if (clk_en)
      st <= next_st;
  end

  assign rsp                   = st.rsp;
  assign ring_run              = st.run;
  assign function_state        = st.status;
  assign config_change_counter = st.gen;
  assign dev_resetting         = (st.dstate == pccr_pkg::PCCR_RESETTING);
  assign notify_addr           = st.naddr;
  assign common_region_off     = st.coff;
  assign common_cap_len        = st.clen;
  assign notify_cap_len        = st.nlen;

  default clocking pccr_cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  a_offer_high_zero: assert property (
    clk_en && acc.req && !acc.wr && acc.addr == `PCCR_OFF_OFFER
    && st.ofsel > `PCCR_SLICE_HI |=> rsp.valid && rsp.rdata == '0)
    else $error("offered slice beyond high word not zero");
  a_accept_subset: assert property (
    (st.accepted & ~OFFERED) == '0)
    else $error("accepted holds a bit that is not offered");
  a_gen_bump: assert property (
    clk_en && dev_cfg_read && st.changed
    |=> st.gen == $past(st.gen) + 8'h01)
    else $error("generation did not advance on pending change");
  a_status_reset: assert property (
    clk_en && acc.req && acc.wr && acc.addr == `PCCR_OFF_STATUS
    && acc.be[0] && acc.wdata[`PCCR_B0] == 8'h00 && !dev_resetting
    |=> dev_resetting && ring_run == '0)
    else $error("status zero did not start device reset");
  a_reset_done: assert property (
    clk_en && dev_resetting && st.dcnt == '0
    |=> !dev_resetting && function_state == 8'h00
    && st.qen == '0 && st.qrst == '0)
    else $error("device reset end left state behind");
  a_size_pow2: assert property (
    !st.accepted[PACKED_BIT] |-> st.qsize[st.qsel[QW-1:0]] == '0
    || is_pow2(st.qsize[st.qsel[QW-1:0]]))
    else $error("queue size not a power of two");
  a_qreset_end: assert property (
    clk_en && st.qbusy && st.qcnt == '0 && !dev_resetting
    && !(acc.req && acc.wr)
    |=> !st.qrst[$past(st.qidx)] && !st.qen[$past(st.qidx)])
    else $error("queue reset end left reset or enable set");
  a_enable_clears: assert property (
    clk_en && acc.req && acc.wr && acc.addr == `PCCR_OFF_QEN
    && acc.be[0] && acc.wdata[0] && st.qsel < 16'(NQ) && !dev_resetting
    |=> st.qen[$past(st.qsel[QW-1:0])]
    && !st.qrst[$past(st.qsel[QW-1:0])])
    else $error("enable write did not clear queue reset");
  a_notify_addr: assert property (
    clk_en ##1 clk_en |-> notify_addr == NOTIFY_OFF
    + STRIDE * 32'(st.qsel[QW-1:0]))
    else $error("notify address mismatch");

  c_dev_reset: cover property (dev_resetting ##1 !dev_resetting);
  c_queue_reset: cover property (st.qbusy ##1 !st.qbusy);
  c_gen_bump: cover property (dev_cfg_read && st.changed);
  c_queue_on: cover property ($rose(|ring_run));

endmodule : pccr_common_cfg

//--- tb/pccr_host_model.sv
// host driver model that issues accesses on the common config port
module pccr_host_model (
  input  wire logic                clock,
  output pccr_pkg::pccr_req_t      acc,
  input  wire pccr_pkg::pccr_rsp_t rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    acc = '0;
  end

  // called at a falling edge; the request stands over one rising edge
  task automatic access(input logic        wr,
                        input logic [7:0]  addr,
                        input logic [3:0]  be,
                        input logic [31:0] wd);
    acc.req   = 1'b1;
    acc.wr    = wr;
    acc.addr  = addr;
    acc.be    = be;
    acc.wdata = wd;
    @(negedge clock);
  endtask : access

  // a released bus shows the inverse of its last value
  task automatic idle();
    acc.req   = 1'b0;
    acc.wr    = ~acc.wr;
    acc.addr  = ~acc.addr;
    acc.be    = ~acc.be;
    acc.wdata = ~acc.wdata;
    @(negedge clock);
  endtask : idle
endmodule : pccr_host_model

//--- tb/tb_top.sv
// self-checking bench for the common configuration register block
`include "pccr_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int          NQ   = 4;
  localparam logic [15:0] QMAX = 16'h0100;
  logic                clock;
  logic                resetn;
  logic                clk_en;
  logic                dev_cfg_changed;
  logic                dev_cfg_read;
  pccr_pkg::pccr_req_t acc;
  pccr_pkg::pccr_rsp_t rsp;
  logic [NQ-1:0]       ring_run;
  logic [7:0]          function_state;
  logic [7:0]          config_change_counter;
  logic                dev_resetting;
  logic [31:0]         notify_addr;
  logic [31:0]         common_region_off;
  logic [7:0]          common_cap_len;
  logic [7:0]          notify_cap_len;
  int                  num_errors;
  int                  comparisons;
  logic [63:0]         exp_q[$];
  logic [63:0]         e;
  logic [31:0]         seed;
  logic [31:0]         lo[NQ];

  pccr_common_cfg #(.NQ(NQ), .QMAX(QMAX), .COMMON_OFF(32'h0000_0106),
    .DEV_RESET_CYCLES(3), .QUEUE_RESET_CYCLES(2)) i_pccr_common_cfg (
    .clock(clock), .resetn(resetn), .clk_en(clk_en), .acc(acc),
    .dev_cfg_changed(dev_cfg_changed), .dev_cfg_read(dev_cfg_read),
    .rsp(rsp), .ring_run(ring_run), .function_state(function_state),
    .config_change_counter(config_change_counter),
    .dev_resetting(dev_resetting), .notify_addr(notify_addr),
    .common_region_off(common_region_off),
    .common_cap_len(common_cap_len), .notify_cap_len(notify_cap_len));
  pccr_host_model i_pccr_host_model (.clock(clock), .acc(acc), .rsp(rsp));

  initial clock = 1'b0;
  always #50 clock = ~clock;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp(input string what, input logic [31:0] ex,
                     input logic [31:0] got);
    comparisons++;
    if (got !== ex)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, ex, got);
    end
  endtask : cmp

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    i_pccr_host_model.access(1'b1, a, be, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    exp_q.push_back({m, ex & m});
    i_pccr_host_model.access(1'b0, a, 4'hF, 32'h0);
  endtask : rd

  task automatic sel(input int q);
    wr(`PCCR_OFF_STATUS, 4'b1100, {q[15:0], 16'h0});
  endtask : sel

  task automatic gap(input int n);
    repeat (n) i_pccr_host_model.idle();
  endtask : gap

  // rereads until the masked bits clear, then checks that they did
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    do
    begin
      rd(a, 32'h0, 32'h0);
      gap(1);
      k++;
    end while ((rsp.rdata & m) !== 32'h0 && k < 40);
    cmp("poll", 32'h0, rsp.rdata & m);
  endtask : poll

  // each read result is matched against the oldest expectation
  always @(negedge clock)
  begin
    if (rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp("read count", 32'h0, 32'h1);
      else
      begin
        e = exp_q.pop_front();
        cmp("rdata", e[31:0], rsp.rdata & e[63:32]);
      end
    end
  end

  initial
  begin
    #(100 * 3000);
    num_errors++;
    conclude();
  end

  initial
  begin
    seed = 32'hc123;
    num_errors = 0;
    comparisons = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    dev_cfg_changed = 1'b0;
    dev_cfg_read = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    cmp("common_cap_len", 32'h10, {24'h0, common_cap_len});
    cmp("notify_cap_len", 32'h14, {24'h0, notify_cap_len});
    cmp("common_region_off", 32'h104, common_region_off);
    rd(`PCCR_OFF_STATUS, 32'h0);
    rd(`PCCR_OFF_QSIZE, {16'h0, QMAX}, 32'h0000_FFFF);
    rd(`PCCR_OFF_QEN, 32'h0);
    rd(`PCCR_OFF_QTAG, 32'h0);
    wr(`PCCR_OFF_OFSEL, 4'hF, 32'h1);
    wr(`PCCR_OFF_OFFER, 4'hF, rnd());
    for (int s = 0; s < 4; s++)
    begin
      wr(`PCCR_OFF_OFSEL, 4'hF, (s == 3) ? 32'hFFFF_FFFF : s);
      rd(`PCCR_OFF_OFFER, (s == 1) ? 32'h184 : 32'h0);
    end
    wr(`PCCR_OFF_ACCSEL, 4'hF, 32'h0);
    wr(`PCCR_OFF_ACCEPT, 4'hF, rnd());
    rd(`PCCR_OFF_ACCEPT, 32'h0);
    wr(`PCCR_OFF_ACCSEL, 4'hF, 32'h1);
    wr(`PCCR_OFF_ACCEPT, 4'hF, (rnd() | 32'h180) & ~32'h4);
    rd(`PCCR_OFF_ACCEPT, 32'h180);
    lo[0] = rnd();
    wr(`PCCR_OFF_MISC, 4'hF, lo[0]);
    rd(`PCCR_OFF_MISC, {16'(NQ), lo[0][15:0]});
    for (int q = 0; q < NQ; q++)
    begin
      sel(q);
      lo[q] = rnd();
      wr(`PCCR_OFF_DESC_LO, 4'hF, lo[q]);
      wr(`PCCR_OFF_DESC_HI, 4'hF, ~lo[q]);
      wr(`PCCR_OFF_QSIZE, 4'b0011, {16'h0, QMAX} >> q);
      wr(`PCCR_OFF_QTAG, 4'b0011, 32'h0000_0055);
    end
    for (int q = NQ; q >= 0; q--)
    begin
      sel(q);
      rd(`PCCR_OFF_DESC_HI, (q < NQ) ? ~lo[q % NQ] : 32'h0);
      rd(`PCCR_OFF_DESC_LO, (q < NQ) ? lo[q % NQ] : 32'h0);
      rd(`PCCR_OFF_QSIZE, (q < NQ) ? {16'h0, QMAX} >> q : 32'h0,
         32'h0000_FFFF);
      rd(`PCCR_OFF_QEN, (q < NQ) ? {q[15:0], 16'h0} : 32'h0);
      rd(`PCCR_OFF_QTAG, (q < NQ) ? q : 32'h0);
      rd(`PCCR_OFF_STRIDE, 32'h4);
      if (q < NQ)
        cmp("notify_addr", 32'h1000 + q * 4, notify_addr);
    end
    sel(1);
    wr(`PCCR_OFF_QSIZE, 4'b0011, 32'h0030);
    rd(`PCCR_OFF_QSIZE, 32'h0080, 32'h0000_FFFF);
    wr(`PCCR_OFF_QEN, 4'hF, 32'h0);
    rd(`PCCR_OFF_QEN, 32'h0001_0000);
    wr(`PCCR_OFF_QEN, 4'hF, 32'h1);
    rd(`PCCR_OFF_QEN, 32'h0001_0001);
    gap(1);
    cmp("ring_run", 32'h2, {28'h0, ring_run});
    wr(`PCCR_OFF_QTAG, 4'b0100, 32'h0001_0000);
    rd(`PCCR_OFF_QTAG, 32'h0001_0001);
    poll(`PCCR_OFF_QTAG, 32'h0001_0000);
    rd(`PCCR_OFF_QEN, 32'h0001_0000);
    rd(`PCCR_OFF_DESC_LO, 32'h0);
    rd(`PCCR_OFF_QSIZE, {16'h0, QMAX}, 32'h0000_FFFF);
    sel(2);
    wr(`PCCR_OFF_QTAG, 4'b0100, 32'h0001_0000);
    wr(`PCCR_OFF_QEN, 4'hF, 32'h1);
    rd(`PCCR_OFF_QTAG, 32'h0000_0002);
    gap(2);
    cmp("ring_run", 32'h4, {28'h0, ring_run});
    dev_cfg_changed = 1'b1;
    @(negedge clock);
    dev_cfg_changed = 1'b0;
    repeat (2)
    begin
      dev_cfg_read = 1'b1;
      @(negedge clock);
      dev_cfg_read = 1'b0;
      @(negedge clock);
      cmp("generation", 32'h1, {24'h0, config_change_counter});
    end
    // with the clock enable low, change and read pulses must be lost
    clk_en = 1'b0;
    dev_cfg_changed = 1'b1;
    dev_cfg_read = 1'b1;
    gap(2);
    clk_en = 1'b1;
    dev_cfg_changed = 1'b0;
    dev_cfg_read = 1'b0;
    cmp("frozen generation", 32'h1, {24'h0, config_change_counter});
    wr(`PCCR_OFF_STATUS, 4'b0001, 32'h0F);
    rd(`PCCR_OFF_STATUS, 32'h0002_010F);
    wr(`PCCR_OFF_STATUS, 4'b0001, 32'h0);
    wr(`PCCR_OFF_STATUS, 4'b0001, 32'h55);
    gap(1);
    cmp("dev_resetting", 32'h1, {31'h0, dev_resetting});
    cmp("ring_run", 32'h0, {28'h0, ring_run});
    poll(`PCCR_OFF_STATUS, 32'h0000_00FF);
    rd(`PCCR_OFF_STATUS, 32'h0000_0100, 32'h0000_FFFF);
    gap(3);
    cmp("dev_resetting", 32'h0, {31'h0, dev_resetting});
    cmp("pending reads", 32'h0, 32'(exp_q.size()));
    conclude();
  end
endmodule : tb_top
